// ==== rtl/lzc_lane_regs.sv ====
/*
 * Lane zero control registers with their byte-wide slave access port,
 * plus the override and checksum gates that steer the lane analog controls.
 * Assumes an upstream slave engine presents single-cycle byte reads/writes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lzc_params.svh"

// What this block does
// - Auto idle bit picks automatic idle detection
// - Mute bit forces output idle when manual
// - Code 00 high-z, code 11 fixed termination
// - Code 01 probes every 12 ms, fifty tries
// - Code 10 probes every 12 ms forever
// - Mode field beats external termination pin
// - Equalizer level eight bits, resets 0x2F
// - Swing bit 7 enables short protection
// - Bit 6 picks older generations, overrides pin
// - Swing code selects 0.7 to 1.4 V
// - Status bit 7 reports receiver found
// - Bits 6:5 report detected rate class
// - De-emphasis code selects eight levels, default 010
// - De-emphasis resets 0x02, status read-only
// - Writes need checksum unless register enable set
// - Global override gates termination field use
// - Global idle override gates idle fields
// - Global mode override gates rate select
module lzc_lane_regs
    import lzc_pkg::*;
#(
    parameter int unsigned PROBE_CYCLES = `LZC_PROBE_CYCLES
) (
    input  wire logic       clk,               // Core clock
    input  wire logic       resetn,            // Async reset, low
    input  wire logic       reg_wr,            // Byte write strobe
    input  wire logic       reg_rd,            // Byte read strobe
    input  wire logic [7:0] reg_addr,          // Register offset
    input  wire logic [7:0] reg_wdata,         // Write data
    input  wire logic [7:0] slave_ctrl,        // Slave control register value
    input  wire logic [7:0] override_ctrl,     // Override pin control value
    input  wire logic       checksum_ok,       // Checksum register correct
    input  wire logic [1:0] term_pin_mode,     // External termination pin
    input  wire logic       mode_pin_gen12,    // External mode pin level
    input  wire logic       mode_pin_auto,     // Mode pin in automatic
    input  wire logic       signal_idle,       // Signal detect says idle
    input  wire logic       detect_hit,        // Far-end probe result
    input  wire logic [1:0] rate_detected,     // Rate class from detector
    output logic [7:0]      reg_rdata,         // Read data
    output logic            reg_rvalid,        // Read data valid
    output logic            out_muted,         // Output in electrical idle
    output logic            in_terminated,     // Input 50 ohm on
    output logic            probe_pulse,       // Probe attempt
    output logic [7:0]      eq_level,          // Equalizer level
    output logic            short_protect,     // Short protection on
    output logic            rate_gen12,        // Gen 1/2 selected
    output logic [2:0]      swing_code,        // Output swing code
    output logic [2:0]      deemph_code        // De-emphasis code
);
    typedef struct packed {
        lzc_byte_t   idle_term;
        lzc_byte_t   eq_level;
        lzc_byte_t   swing;
        logic [1:0]  deemph_rsvd;
        logic [2:0]  deemph_code;
        lzc_byte_t   rdata;
        logic        rvalid;
        logic        muted;
        logic        gen12;
        logic [1:0]  rate_seen;
        logic        restart;
    } lzc_reg_s;

    lzc_reg_s   r;
    lzc_reg_s   next_r;
    logic       found;
    logic       seq_term;
    logic       seq_pulse;
    logic       wr_ok;
    logic [1:0] eff_mode;

    // Field byte of the status register, used only by the read mux
    function automatic lzc_byte_t deemph_byte(input logic fnd, input logic [1:0] rate,
                                              input logic [1:0] rsvd, input logic [2:0] code);
        deemph_byte = {fnd, rate, rsvd, code};
    endfunction : deemph_byte

    // Writes pass only with register enable or a correct checksum
    assign wr_ok = reg_wr && (slave_ctrl[`LZC_BIT_REG_ENABLE] || checksum_ok);

    // Register field wins over the pin only under global override
    assign eff_mode = override_ctrl[`LZC_BIT_OVR_TERM] ? r.idle_term[3:2] : term_pin_mode;

    lzc_probe_seq #(
        .PROBE_CYCLES (PROBE_CYCLES)
    ) u_probe (
        .clk         (clk),
        .resetn      (resetn),
        .mode        (eff_mode),
        .restart     (r.restart),
        .detect_hit  (detect_hit),
        .probe_pulse (seq_pulse),
        .found       (found),
        .terminate   (seq_term)
    );

    // Register writes, read mux and derived controls
    always_comb begin
        next_r = r;
        next_r.restart = 1'b0;
        next_r.rvalid = reg_rd;
        if (wr_ok) begin
            case (reg_addr)
                `LZC_OFS_IDLE_TERM: begin
                    next_r.idle_term = reg_wdata;
                    next_r.restart = reg_wdata[3:2] != r.idle_term[3:2];
                end
                `LZC_OFS_EQ_LEVEL: next_r.eq_level = reg_wdata;
                `LZC_OFS_SWING:    next_r.swing = reg_wdata;
                `LZC_OFS_DEEMPH: begin
                    next_r.deemph_rsvd = reg_wdata[4:3];
                    next_r.deemph_code = reg_wdata[2:0];
                end
                default: next_r.restart = 1'b0;
            endcase
        end
        // Rate class report only means something in automatic mode
        next_r.rate_seen = mode_pin_auto ? rate_detected : 2'b00;
        if (reg_rd) begin
            case (reg_addr)
                `LZC_OFS_IDLE_TERM: next_r.rdata = r.idle_term;
                `LZC_OFS_EQ_LEVEL:  next_r.rdata = r.eq_level;
                `LZC_OFS_SWING:     next_r.rdata = r.swing;
                `LZC_OFS_DEEMPH:    next_r.rdata = deemph_byte(found, r.rate_seen,
                                                   r.deemph_rsvd, r.deemph_code);
                default:            next_r.rdata = 8'h00;
            endcase
        end
        // Mute decision: registers only under global idle override
        if (!override_ctrl[`LZC_BIT_OVR_IDLE]) begin
            next_r.muted = signal_idle;
        end else if (r.idle_term[`LZC_BIT_IDLE_AUTO]) begin
            next_r.muted = signal_idle;
        end else begin
            next_r.muted = r.idle_term[`LZC_BIT_IDLE_MUTE];
        end
        next_r.gen12 = override_ctrl[`LZC_BIT_OVR_MODE] ? r.swing[`LZC_BIT_RATE_SEL]
                                                        : mode_pin_gen12;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{idle_term: `LZC_RST_IDLE_TERM, eq_level: `LZC_RST_EQ_LEVEL,
                   swing: `LZC_RST_SWING, deemph_rsvd: 2'h0, deemph_code: 3'h2,
                   rdata: 8'h00, rvalid: 1'b0, muted: 1'b0, gen12: 1'b0,
                   rate_seen: 2'h0, restart: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata     = r.rdata;
    assign reg_rvalid    = r.rvalid;
    assign out_muted     = r.muted;
    assign in_terminated = seq_term;
    assign probe_pulse   = seq_pulse;
    assign eq_level      = r.eq_level;
    assign short_protect = r.swing[`LZC_BIT_SHORT_PROT];
    assign rate_gen12    = r.gen12;
    assign swing_code    = r.swing[2:0];
    assign deemph_code   = r.deemph_code;

    // Antecedents skip the release edge, where the flops still sit in reset
    a_manual_mute: assert property (@(posedge clk) disable iff (!resetn)
        resetn && override_ctrl[4] && !r.idle_term[5] |=> out_muted == $past(r.idle_term[4]))
        else $error("manual mute not followed");
    a_auto_idle: assert property (@(posedge clk) disable iff (!resetn)
        resetn && override_ctrl[4] && r.idle_term[5] |=> out_muted == $past(signal_idle))
        else $error("auto idle not followed");
    a_idle_gate: assert property (@(posedge clk) disable iff (!resetn)
        resetn && !override_ctrl[4] |=> out_muted == $past(signal_idle))
        else $error("idle ignored signal detect");
    a_write_gate: assert property (@(posedge clk) disable iff (!resetn)
        reg_wr && reg_addr == 8'h0F && !slave_ctrl[3] && !checksum_ok |=> $stable(eq_level))
        else $error("unchecked write landed");
    a_eq_write: assert property (@(posedge clk) disable iff (!resetn)
        reg_wr && reg_addr == 8'h0F && slave_ctrl[3] |=> eq_level == $past(reg_wdata))
        else $error("equalizer write lost");
    a_status_ro: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == 8'h11 |=> reg_rdata[7] == $past(found) && reg_rvalid)
        else $error("status bit misreported");
    a_rate_gate: assert property (@(posedge clk) disable iff (!resetn)
        resetn && override_ctrl[2] |=> rate_gen12 == $past(r.swing[6]))
        else $error("rate select not applied");
    a_rate_pin: assert property (@(posedge clk) disable iff (!resetn)
        resetn && !override_ctrl[2] |=> rate_gen12 == $past(mode_pin_gen12))
        else $error("mode pin not followed");
    a_term_pin: assert property (@(posedge clk) disable iff (!resetn)
        resetn && !override_ctrl[3] && term_pin_mode == 2'b11 |=> in_terminated)
        else $error("pin termination ignored");
endmodule : lzc_lane_regs
`default_nettype wire

// ==== include/lzc_params.svh ====
/*
 * Offsets, field positions, reset values and timing counts for the lane zero
 * control register bank. Assumes a 40 MHz core clock.
 */
`ifndef LZC_PARAMS_SVH
`define LZC_PARAMS_SVH

`define LZC_CLK_HZ            40000000
// Register offsets
`define LZC_OFS_SLAVE_CTRL    8'h06
`define LZC_OFS_OVERRIDE      8'h08
`define LZC_OFS_IDLE_TERM     8'h0E
`define LZC_OFS_EQ_LEVEL      8'h0F
`define LZC_OFS_SWING         8'h10
`define LZC_OFS_DEEMPH        8'h11
// Reset values
`define LZC_RST_IDLE_TERM     8'h00
`define LZC_RST_EQ_LEVEL      8'h2F
`define LZC_RST_SWING         8'hAD
`define LZC_RST_DEEMPH        8'h02
// Field positions
`define LZC_BIT_IDLE_AUTO     5
`define LZC_BIT_IDLE_MUTE     4
`define LZC_BIT_SHORT_PROT    7
`define LZC_BIT_RATE_SEL      6
`define LZC_BIT_REG_ENABLE    3
`define LZC_BIT_OVR_IDLE      4
`define LZC_BIT_OVR_TERM      3
`define LZC_BIT_OVR_MODE      2
// Probe timing
`define LZC_PROBE_MS          12
`define LZC_PROBE_LIMIT_MS    600
`define LZC_PROBE_CYCLES      ((`LZC_CLK_HZ / 1000) * `LZC_PROBE_MS)
`define LZC_PROBE_ATTEMPTS    (`LZC_PROBE_LIMIT_MS / `LZC_PROBE_MS)

`endif

// ==== include/lzc_pkg.sv ====
/*
 * Types shared by the lane zero control register bank.
 * Assumes the params header is included by each user.
 */
package lzc_pkg;
    typedef enum logic [1:0] {
        LZC_TERM_HIGHZ,
        LZC_TERM_AUTO_LIMITED,
        LZC_TERM_AUTO_FOREVER,
        LZC_TERM_FIXED_50
    } lzc_term_mode_e;

    typedef enum logic [1:0] {
        LZC_PRB_IDLE,
        LZC_PRB_WAIT,
        LZC_PRB_FOUND,
        LZC_PRB_STOPPED
    } lzc_prb_state_e;

    typedef logic [7:0] lzc_byte_t;
endpackage : lzc_pkg

// ==== rtl/lzc_probe_seq.sv ====
/*
 * Far-end receiver probe sequencer for lane zero.
 * Assumes detect_hit is synchronous to clk and sampled after each probe pulse.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lzc_params.svh"

module lzc_probe_seq
    import lzc_pkg::*;
#(
    parameter int unsigned PROBE_CYCLES = `LZC_PROBE_CYCLES
) (
    input  wire logic       clk,          // Core clock
    input  wire logic       resetn,       // Async reset, low
    input  wire logic [1:0] mode,         // Effective detect mode
    input  wire logic       restart,      // Mode field written with a new code
    input  wire logic       detect_hit,   // Probe result
    output logic            probe_pulse,  // One probe attempt
    output logic            found,        // Receiver found
    output logic            terminate     // 50 ohm applied
);
    typedef struct packed {
        lzc_prb_state_e st;
        logic [22:0]    tick;
        logic [5:0]     tries;
        logic           probe_pulse;
        logic           found;
        logic           terminate;
    } lzc_prb_s;

    localparam logic [5:0] LAST_TRY = 6'(`LZC_PROBE_ATTEMPTS);

    lzc_prb_s cur;
    lzc_prb_s next_cur;

    // Sequencer; a restart always wins over any probe in flight
    always_comb begin
        next_cur = cur;
        next_cur.probe_pulse = 1'b0;
        case (cur.st)
            LZC_PRB_IDLE: begin
                next_cur.tick = 23'h000000;
                next_cur.tries = 6'h00;
                if (mode == 2'b01 || mode == 2'b10) begin
                    next_cur.st = LZC_PRB_WAIT;
                end
            end
            LZC_PRB_WAIT: begin
                if (detect_hit && cur.tries != 6'h00) begin
                    next_cur.st = LZC_PRB_FOUND;
                    next_cur.found = 1'b1;
                end else if (cur.tick == 23'(PROBE_CYCLES - 1)) begin
                    next_cur.tick = 23'h000000;
                    if (mode == 2'b01 && cur.tries == LAST_TRY) begin
                        next_cur.st = LZC_PRB_STOPPED;
                    end else begin
                        next_cur.probe_pulse = 1'b1;
                        if (cur.tries != LAST_TRY) begin
                            next_cur.tries = cur.tries + 6'h01; // Saturates
                        end
                    end
                end else begin
                    next_cur.tick = cur.tick + 23'h000001;
                end
            end
            LZC_PRB_FOUND: next_cur.found = 1'b1;
            LZC_PRB_STOPPED: next_cur.found = 1'b0;
            default: next_cur.st = LZC_PRB_IDLE;
        endcase
        if (restart || mode == 2'b00 || mode == 2'b11) begin
            next_cur.st = LZC_PRB_IDLE;
            next_cur.found = 1'b0;
            next_cur.probe_pulse = 1'b0;
        end
        next_cur.terminate = (mode == 2'b11) || next_cur.found;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= '{st: LZC_PRB_IDLE, tick: 23'h000000, tries: 6'h00,
                     probe_pulse: 1'b0, found: 1'b0, terminate: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign probe_pulse = cur.probe_pulse;
    assign found       = cur.found;
    assign terminate   = cur.terminate;

    // Antecedents skip the release edge, where the flops still sit in reset
    a_probe_saturate: assert property (@(posedge clk) disable iff (!resetn)
        cur.tries <= LAST_TRY) else $error("probe count passed its limit");
    a_restart_clears: assert property (@(posedge clk) disable iff (!resetn)
        restart |=> !found) else $error("restart left found set");
    a_fixed_term: assert property (@(posedge clk) disable iff (!resetn)
        resetn && mode == 2'b11 |=> terminate) else $error("fixed code lost termination");
    a_highz_term: assert property (@(posedge clk) disable iff (!resetn)
        resetn && mode == 2'b00 |=> !terminate) else $error("high-z code terminated");
endmodule : lzc_probe_seq
`default_nettype wire

// ==== tb/lzc_far_rcvr.sv ====
/*
 * Far-end receiver model: answers lane probes with a found level.
 * Assumes probe_pulse is a one-cycle pulse synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module lzc_far_rcvr (
    input  wire logic       clk,         // Core clock
    input  wire logic       resetn,      // Async reset, low
    input  wire logic       clr,         // Unplug, forget probes
    input  wire logic       probe_pulse, // Probe from lane
    input  wire logic [7:0] hit_after,   // Probes until seen, 0 never
    output logic            detect_hit   // Receiver seen
);
    logic [7:0] cnt;

    // Count probes; a receiver only answers once probed often enough
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
        end else if (clr) begin
            cnt <= 8'h00;
        end else if (probe_pulse && cnt != 8'hFF) begin
            cnt <= cnt + 8'h01;
        end
    end

    // Level stays up: a present receiver does not vanish between probes
    assign detect_hit = (hit_after != 8'h00) && (cnt >= hit_after);
endmodule : lzc_far_rcvr

`default_nettype wire

// ==== tb/lane_zero_control_registers_test.sv ====
/*
 * Self-checking bench for the lane zero register bank.
 * Assumes the probe period is shortened to 20 cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module lane_zero_control_registers_test;
    localparam int unsigned PC = 20;
    logic       clk, resetn, reg_wr, reg_rd, checksum_ok, mode_pin_gen12, mode_pin_auto;
    logic       signal_idle, clr, reg_rvalid, out_muted, in_terminated, probe_pulse;
    logic       short_protect, rate_gen12, detect_hit;
    logic [7:0] reg_addr, reg_wdata, slave_ctrl, override_ctrl, reg_rdata, eq_level;
    logic [7:0] hit_after, pcnt, gap;
    logic [1:0] term_pin_mode, rate_detected;
    logic [2:0] swing_code, deemph_code;
    int         error_cnt, n_compared, cyc, last;

    lzc_lane_regs #(.PROBE_CYCLES(PC)) u_dut (
        .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .slave_ctrl(slave_ctrl), .override_ctrl(override_ctrl),
        .checksum_ok(checksum_ok), .term_pin_mode(term_pin_mode), .mode_pin_gen12(mode_pin_gen12),
        .mode_pin_auto(mode_pin_auto), .signal_idle(signal_idle), .detect_hit(detect_hit),
        .rate_detected(rate_detected), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .out_muted(out_muted), .in_terminated(in_terminated), .probe_pulse(probe_pulse),
        .eq_level(eq_level), .short_protect(short_protect), .rate_gen12(rate_gen12),
        .swing_code(swing_code), .deemph_code(deemph_code));

    lzc_far_rcvr u_rcvr (.clk(clk), .resetn(resetn), .clr(clr), .probe_pulse(probe_pulse),
        .hit_after(hit_after), .detect_hit(detect_hit));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Probe counter and spacing of the last two probes
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (clr) begin
            pcnt <= 8'h00;
        end else if (probe_pulse === 1'b1) begin
            pcnt <= pcnt + 8'h01;
            gap  <= 8'(cyc - last);
            last <= cyc;
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read one byte and judge both the valid pulse and the data
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask : rd

    // Outputs are read at an edge, before that edge updates them, so that
    // every level change afterwards lands on the rising edge
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    // Bounded wait; a miss shows up in the following compares
    task automatic wait_cnt(input logic [7:0] n);
        int k;
        for (k = 0; k < 2000 && pcnt !== n; k++) @(posedge clk);
        chk("probes", n, pcnt);
    endtask : wait_cnt

    task automatic t_reset;
        rd(8'h0E, 8'h00);
        rd(8'h0F, 8'h2F);
        rd(8'h10, 8'hAD);
        rd(8'h11, 8'h02);
        rd(8'h12, 8'h00);
        chk("swing", 8'h05, {5'h00, swing_code});
        chk("deemph", 8'h02, {5'h00, deemph_code});
    endtask : t_reset

    task automatic t_gate;
        wr(8'h0F, 8'h10);
        rd(8'h0F, 8'h2F);
        checksum_ok <= 1'b1;
        wr(8'h0F, 8'h33);
        rd(8'h0F, 8'h33);
        checksum_ok <= 1'b0;
        slave_ctrl <= 8'h08;
        wr(8'h0F, 8'hFF);
        rd(8'h0F, 8'hFF);
        chk("eq", 8'hFF, eq_level);
    endtask : t_gate

    task automatic t_deemph;
        wr(8'h11, 8'hFF);
        rd(8'h11, 8'h1F);
        mode_pin_auto <= 1'b1;
        rate_detected <= 2'b11;
        settle();
        rd(8'h11, 8'h7F);
        chk("deemph", 8'h07, {5'h00, deemph_code});
        mode_pin_auto <= 1'b0;
    endtask : t_deemph

    // Swing byte: short protection, swing code, rate select from pin then register
    task automatic t_swing;
        mode_pin_gen12 <= 1'b1;
        wr(8'h10, 8'h2A);
        settle();
        chk("short", 8'h00, {7'h00, short_protect});
        chk("swing", 8'h02, {5'h00, swing_code});
        chk("rate pin", 8'h01, {7'h00, rate_gen12});
        override_ctrl <= 8'h04;
        settle();
        chk("rate reg", 8'h00, {7'h00, rate_gen12});
        wr(8'h10, 8'hEF);
        settle();
        chk("short", 8'h01, {7'h00, short_protect});
        chk("rate reg", 8'h01, {7'h00, rate_gen12});
        chk("swing", 8'h07, {5'h00, swing_code});
    endtask : t_swing

    task automatic t_idle;
        override_ctrl <= 8'h00;
        signal_idle <= 1'b1;
        wr(8'h0E, 8'h10);
        settle();
        chk("mute sd", 8'h01, {7'h00, out_muted});
        signal_idle <= 1'b0;
        settle();
        chk("mute sd", 8'h00, {7'h00, out_muted});
        override_ctrl <= 8'h10;
        settle();
        chk("mute sel", 8'h01, {7'h00, out_muted});
        wr(8'h0E, 8'h30);
        settle();
        chk("mute auto", 8'h00, {7'h00, out_muted});
        signal_idle <= 1'b1;
        settle();
        chk("mute auto", 8'h01, {7'h00, out_muted});
        wr(8'h0E, 8'h00);
        settle();
        chk("mute sel", 8'h00, {7'h00, out_muted});
    endtask : t_idle

    task automatic t_term;
        override_ctrl <= 8'h08;
        term_pin_mode <= 2'b00;
        wr(8'h0E, 8'h0C);
        settle();
        chk("term", 8'h01, {7'h00, in_terminated});
        term_pin_mode <= 2'b11;
        wr(8'h0E, 8'h00);
        settle();
        chk("term", 8'h00, {7'h00, in_terminated});
        override_ctrl <= 8'h00;
        settle();
        chk("term pin", 8'h01, {7'h00, in_terminated});
    endtask : t_term

    // Unlimited probing, receiver appears at the third probe
    task automatic t_probe;
        override_ctrl <= 8'h08;
        term_pin_mode <= 2'b00;
        hit_after <= 8'h03;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr(8'h0E, 8'h08);
        wait_cnt(8'h02);
        chk("term early", 8'h00, {7'h00, in_terminated});
        wait_cnt(8'h03);
        settle();
        chk("term", 8'h01, {7'h00, in_terminated});
        chk("gap", 8'(PC), gap);
        rd(8'h11, 8'h9F);
        repeat (4 * PC) @(posedge clk);
        chk("probes", 8'h03, pcnt);
    endtask : t_probe

    // Limited probing with nobody there; the mode change also restarts
    task automatic t_limit;
        hit_after <= 8'h00;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr(8'h0E, 8'h04);
        settle();
        chk("term", 8'h00, {7'h00, in_terminated});
        rd(8'h11, 8'h1F);
        repeat (60 * PC) @(posedge clk);
        chk("probes", 8'd50, pcnt);
        chk("term", 8'h00, {7'h00, in_terminated});
    endtask : t_limit

    // Mid-run reset must bring every rewritten field back to its default
    task automatic t_rerun;
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h0E, 8'h00);
        rd(8'h0F, 8'h2F);
        rd(8'h10, 8'hAD);
        rd(8'h11, 8'h02);
        chk("short", 8'h01, {7'h00, short_protect});
        chk("term", 8'h00, {7'h00, in_terminated});
    endtask : t_rerun

    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        {resetn, reg_wr, reg_rd, checksum_ok, mode_pin_gen12, mode_pin_auto, signal_idle, clr} = '0;
        {reg_addr, reg_wdata, slave_ctrl, override_ctrl, hit_after} = '0;
        term_pin_mode = 2'b00;
        rate_detected = 2'b00;
        {error_cnt, n_compared, cyc, last} = '0;
        pcnt = 8'h00;
        gap = 8'h00;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_gate();
        t_deemph();
        t_swing();
        t_idle();
        t_term();
        t_probe();
        t_limit();
        t_rerun();
        wrap_up();
    end

    // Whole run needs about 1500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule : lane_zero_control_registers_test

`default_nettype wire
